// [logic/wdrc_top.sv]
// Watchdog reload, request enable, magic reload and pause configuration
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module wdrc_top
   import wdrc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic        cpu_sleep,
   input  wire logic        cpu_halt,
   output logic      [31:0] rdata,
   output logic             irq,
   output logic             wdog_reset,
   output logic             run_indicator
);
   // ==========================================================
   // Pin synchronisers for the CPU state inputs
   logic [1:0] sleep_sy_ff; // Sleep synchroniser
   logic [1:0] halt_sy_ff;  // Halt synchroniser
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sleep_sy_ff <= 2'h0;
         halt_sy_ff  <= 2'h0;
      end else begin
         sleep_sy_ff <= {sleep_sy_ff[0], cpu_sleep};
         halt_sy_ff  <= {halt_sy_ff[0], cpu_halt};
      end
   end
   wire sleep_s = sleep_sy_ff[1]; // Synchronised sleep
   wire halt_s  = halt_sy_ff[1];  // Synchronised halt

   // ==========================================================
   // Low-frequency tick
   wdrc_tick_if tk ();
   wdrc_tick_gen u_tick (
      .clock (clock),
      .nrst  (nrst),
      .tk    (tk)
   );

   // ==========================================================
   // Registers
   logic [31:0] reload_count_ff;        // Reload value
   logic [7:0]  request_enable_mask_ff; // Per-request enables
   logic [1:0]  pause_cfg_ff;           // [0] sleep run, [1] halt run
   logic [7:0]  reload_request_ff;      // Requests received
   logic        int_mask_ff;            // Timeout interrupt enable
   logic        int_stat_ff;            // Sticky timeout status
   logic [31:0] count_ff;               // Down-counter
   logic        pend_ff;                // Reset pending after timeout
   logic [1:0]  delay_ff;               // Ticks left before reset
   logic [31:0] nxt_rdata;              // Read mux output

   // ==========================================================
   // Address decode
   wire sel_start  = wr_en && (addr == WDRC_OFF_START);
   wire sel_reload = wr_en && (addr == WDRC_OFF_RELOAD);
   wire sel_enmask = wr_en && (addr == WDRC_OFF_ENMASK);
   wire sel_pause  = wr_en && (addr == WDRC_OFF_PAUSE);
   wire sel_mask   = wr_en && (addr == WDRC_OFF_INTMASK);
   wire sel_rr     = wr_en && (addr >= WDRC_OFF_RRBASE) && (addr <= WDRC_OFF_RREND)
                     && (addr[1:0] == 2'h0);
   wire [2:0] rr_idx   = addr[4:2];             // Request index
   wire       is_magic = (wdata == WDRC_MAGIC); // Magic value written
   wire       rd_stat  = rd_en && (addr == WDRC_OFF_INTSTAT);

   wire cfg_open = !run_indicator;

   // ==========================================================
   // Reload condition and counting
   // All enabled requests seen
   wire all_req   = &(reload_request_ff | ~request_enable_mask_ff);
   wire sleep_ps  = sleep_s && !pause_cfg_ff[WDRC_BIT_SLEEP];
   wire halt_ps   = halt_s && !pause_cfg_ff[WDRC_BIT_HALT];
   wire count_on  = run_indicator && tk.tick && !sleep_ps && !halt_ps;
   // Wrap from zero is the timeout
   wire timeout   = count_on && (count_ff == 32'h00000000) && !pend_ff;

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reload_count_ff        <= WDRC_RST_RELOAD;
         request_enable_mask_ff <= WDRC_RST_ENMASK;
         pause_cfg_ff           <= WDRC_RST_PAUSE;
         int_mask_ff            <= 1'b0;
      end else begin
         if (sel_reload && cfg_open) begin
            reload_count_ff <= (wdata < WDRC_MIN_RELOAD) ? WDRC_MIN_RELOAD : wdata;
         end
         if (sel_enmask && cfg_open) begin
            request_enable_mask_ff <= wdata[7:0];
         end
         if (sel_pause && cfg_open) begin
            pause_cfg_ff <= {wdata[WDRC_POS_HALT], wdata[WDRC_BIT_SLEEP]};
         end
         // Interrupt mask stays writable while running
         if (sel_mask) begin
            int_mask_ff <= wdata[0];
         end
      end
   end

   // ==========================================================
   // Reload requests, counter, run state
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reload_request_ff <= 8'h00;
         count_ff          <= WDRC_RST_RELOAD;
         run_indicator     <= 1'b0;
      end else begin
         if (sel_start && wdata[0] && !run_indicator) begin
            run_indicator <= 1'b1;
            count_ff      <= reload_count_ff;
         end else if (run_indicator && all_req) begin
            count_ff          <= reload_count_ff;
            reload_request_ff <= 8'h00;
         end else if (count_on) begin
            count_ff <= count_ff - 32'h00000001;
         end
         if (sel_rr && is_magic && run_indicator && !all_req) begin
            reload_request_ff[rr_idx] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Timeout status, interrupt and reset sequencing
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         int_stat_ff <= 1'b0;
         pend_ff     <= 1'b0;
         delay_ff    <= 2'h0;
         wdog_reset  <= 1'b0;
         irq         <= 1'b0;
      end else begin
         // Set wins over read-clear
         int_stat_ff <= timeout | (int_stat_ff & !rd_stat);
         irq         <= (timeout | (int_stat_ff & !rd_stat)) & int_mask_ff;
         // Delay only when interrupt enabled; cannot cancel
         if (timeout) begin
            pend_ff  <= 1'b1;
            delay_ff <= int_mask_ff ? WDRC_RST_DELAY : 2'h0;
         end else if (pend_ff && delay_ff != 2'h0 && tk.tick) begin
            delay_ff <= delay_ff - 2'h1;
         end
         wdog_reset <= wdog_reset | (pend_ff && delay_ff == 2'h0);
      end
   end

   // ==========================================================
   // Read mux; write-only and unmapped read zero
   always_comb begin
      nxt_rdata = 32'h00000000;
      case (addr)
         WDRC_OFF_INTSTAT: nxt_rdata = {31'h0, int_stat_ff};
         WDRC_OFF_INTMASK: nxt_rdata = {31'h0, int_mask_ff};
         WDRC_OFF_RUN:     nxt_rdata = {31'h0, run_indicator};
         WDRC_OFF_REQ:     nxt_rdata = {24'h0, request_enable_mask_ff & ~reload_request_ff};
         WDRC_OFF_RELOAD:  nxt_rdata = reload_count_ff;
         WDRC_OFF_ENMASK:  nxt_rdata = {24'h0, request_enable_mask_ff};
         WDRC_OFF_PAUSE:   nxt_rdata = {28'h0, pause_cfg_ff[1], 2'h0, pause_cfg_ff[0]};
         default:          nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rd_en ? nxt_rdata : 32'h00000000;
      end
   end

   // ==========================================================
   // Checks
   sequence wrap_seen;
      timeout;
   endsequence

   reload_floor_a: assert property (@(posedge clock) disable iff (!nrst)
      reload_count_ff >= WDRC_MIN_RELOAD) else $error("reload below minimum");
   enmask_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> request_enable_mask_ff == WDRC_RST_ENMASK)
      else $error("enable mask reset wrong");
   sleep_pause_a: assert property (@(posedge clock) disable iff (!nrst)
      (sleep_s && !pause_cfg_ff[0] && run_indicator && !all_req && !sel_start)
      |=> count_ff == $past(count_ff)) else $error("counted while sleep paused");
   halt_pause_a: assert property (@(posedge clock) disable iff (!nrst)
      (halt_s && !pause_cfg_ff[1] && run_indicator && !all_req && !sel_start)
      |=> count_ff == $past(count_ff)) else $error("counted while halt paused");
   magic_mark_a: assert property (@(posedge clock) disable iff (!nrst)
      (sel_rr && is_magic && run_indicator && !all_req)
      |=> reload_request_ff[$past(rr_idx)] || count_ff == reload_count_ff)
      else $error("magic write lost");
   reload_all_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && all_req && !sel_start) |=> count_ff == reload_count_ff)
      else $error("reload missing");
   timeout_stat_a: assert property (@(posedge clock) disable iff (!nrst)
      wrap_seen |=> int_stat_ff) else $error("timeout not flagged");
   reset_fast_a: assert property (@(posedge clock) disable iff (!nrst)
      (wrap_seen and !int_mask_ff) |-> ##2 wdog_reset) else $error("reset late");
   cfg_lock_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && sel_reload) |=> $stable(reload_count_ff))
      else $error("reload changed while running");
   nonmagic_a: assert property (@(posedge clock) disable iff (!nrst)
      (sel_rr && !is_magic && !all_req) |=> $stable(reload_request_ff))
      else $error("non-magic write changed request");

   // ==========================================================
   // Further checks on start, locking, requests and reset timing
   // Sequences name the steps, each used by one property below
   sequence start_wr;
      sel_start && wdata[0] && !run_indicator;
   endsequence

   sequence magic_wr;
      sel_rr && is_magic && run_indicator && !all_req;
   endsequence

   sequence read_stat;
      rd_stat;
   endsequence

   // Start loads the counter from the reload value
   start_load_a: assert property (@(posedge clock) disable iff (!nrst)
      start_wr |=> run_indicator && count_ff == $past(reload_count_ff))
      else $error("start did not load counter");

   // Only a reset stops the watchdog again
   run_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
      run_indicator |=> run_indicator)
      else $error("run indicator dropped");

   // Counter frozen until started
   idle_count_a: assert property (@(posedge clock) disable iff (!nrst)
      (!run_indicator && !sel_start) |=> $stable(count_ff))
      else $error("counter moved before start");

   // Enable mask locked while running
   enmask_lock_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && sel_enmask) |=> $stable(request_enable_mask_ff))
      else $error("enable mask changed while running");

   // Pause configuration locked while running
   pause_lock_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && sel_pause) |=> $stable(pause_cfg_ff))
      else $error("pause config changed while running");

   // Enable mask takes the written byte before start
   enmask_write_a: assert property (@(posedge clock) disable iff (!nrst)
      (!run_indicator && sel_enmask) |=> request_enable_mask_ff == $past(wdata[7:0]))
      else $error("enable mask write lost");

   // Sleep keeps running after reset
   pause_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> pause_cfg_ff[WDRC_BIT_SLEEP])
      else $error("sleep config reset wrong");

   // Halt pauses after reset
   halt_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> !pause_cfg_ff[WDRC_BIT_HALT])
      else $error("halt config reset wrong");

   // Reload value comes out of reset as all ones
   reload_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> reload_count_ff == WDRC_RST_RELOAD)
      else $error("reload reset wrong");

   // In-range reload values are kept as written
   reload_write_a: assert property (@(posedge clock) disable iff (!nrst)
      (!run_indicator && sel_reload && wdata >= WDRC_MIN_RELOAD)
      |=> reload_count_ff == $past(wdata)) else $error("reload write lost");

   // A magic write leaves at least one request pending
   magic_req_a: assert property (@(posedge clock) disable iff (!nrst)
      magic_wr |=> reload_request_ff != 8'h00)
      else $error("magic write not recorded");

   // Requests are not collected before start
   req_idle_a: assert property (@(posedge clock) disable iff (!nrst)
      !run_indicator |=> $stable(reload_request_ff))
      else $error("request taken before start");

   // The first write-only request word, at the array base, reads back zero
   rdata_wo_a: assert property (@(posedge clock) disable iff (!nrst)
      (rd_en && addr == WDRC_OFF_RRBASE) |=> rdata == 32'h00000000)
      else $error("request word readable");

   // A completed set of requests is consumed
   req_clear_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && all_req) |=> reload_request_ff == 8'h00)
      else $error("requests not cleared");

   // No reload and no count without a tick or full set
   hold_count_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && !all_req && !count_on) |=> $stable(count_ff))
      else $error("counter moved without cause");

   // One step down per counted tick, wrapping from zero
   count_step_a: assert property (@(posedge clock) disable iff (!nrst)
      (run_indicator && !all_req && count_on)
      |=> count_ff == $past(count_ff) - 32'h00000001) else $error("bad count step");

   // Status stays set until read
   stat_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      (int_stat_ff && !rd_stat) |=> int_stat_ff)
      else $error("status lost without read");

   // Read clears status when no new timeout competes
   stat_clear_a: assert property (@(posedge clock) disable iff (!nrst)
      (read_stat and !timeout) |=> !int_stat_ff)
      else $error("status read did not clear");

   // Masked timeout never raises the interrupt
   irq_mask_a: assert property (@(posedge clock) disable iff (!nrst)
      !int_mask_ff |=> !irq)
      else $error("irq while masked");

   // With the interrupt enabled the reset waits for ticks
   reset_masked_a: assert property (@(posedge clock) disable iff (!nrst)
      (wrap_seen and int_mask_ff) |=> !wdog_reset ##1 !wdog_reset)
      else $error("reset not postponed");

   // Once issued the reset cannot be withdrawn
   reset_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
      wdog_reset |=> wdog_reset)
      else $error("reset withdrawn");

   // Postponement counts only on ticks
   delay_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      (pend_ff && !tk.tick) |=> $stable(delay_ff))
      else $error("reset delay moved off tick");
endmodule

// [logic/wdrc_pkg.sv]
// Package of register map, reset values and constants for the watchdog reload block
package wdrc_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] WDRC_OFF_START   = 12'h000; // Start task
   localparam logic [11:0] WDRC_OFF_INTSTAT = 12'h100; // Sticky event status, read clears
   localparam logic [11:0] WDRC_OFF_INTMASK = 12'h304; // Interrupt mask
   localparam logic [11:0] WDRC_OFF_RUN     = 12'h400; // Run indicator
   localparam logic [11:0] WDRC_OFF_REQ     = 12'h404; // Request indicator
   localparam logic [11:0] WDRC_OFF_RELOAD  = 12'h504; // Reload count
   localparam logic [11:0] WDRC_OFF_ENMASK  = 12'h508; // Request enable mask
   localparam logic [11:0] WDRC_OFF_PAUSE   = 12'h50C; // Pause configuration
   localparam logic [11:0] WDRC_OFF_RRBASE  = 12'h600; // Reload request array base
   localparam logic [11:0] WDRC_OFF_RREND   = 12'h61C; // Last reload request word
   // ==========================================================
   // Reset values and fields
   localparam logic [31:0] WDRC_RST_RELOAD  = 32'hFFFFFFFF; // Reload count after reset
   localparam logic [31:0] WDRC_MIN_RELOAD  = 32'h0000000F; // Smallest accepted reload
   localparam logic [7:0]  WDRC_RST_ENMASK  = 8'h01;        // Only request 0 enabled
   localparam logic [1:0]  WDRC_RST_PAUSE   = 2'h1;         // Sleep runs, halt pauses
   localparam int          WDRC_BIT_SLEEP   = 0;            // Sleep keep-running bit
   localparam int          WDRC_BIT_HALT    = 1;            // Halt keep-running bit (bit 3)
   localparam int          WDRC_POS_HALT    = 3;            // Halt bit position in word
   localparam logic [31:0] WDRC_MAGIC       = 32'h6E524635; // Reload request value
   localparam int          WDRC_NUM_REQ     = 8;            // Number of request registers
   // ==========================================================
   // Timing: low-frequency tick and reset delay
   localparam int          WDRC_CLK_HZ      = 100000000;    // System clock rate
   localparam int          WDRC_LF_HZ       = 32768;        // Low-frequency clock rate
   localparam int          WDRC_LF_DIV      = WDRC_CLK_HZ / WDRC_LF_HZ; // Cycles per tick
   localparam logic [1:0]  WDRC_RST_DELAY   = 2'h2;         // Ticks to postpone reset
endpackage

// [logic/wdrc_tick_if.sv]
// Interface carrying the low-frequency tick between divider and main block
`timescale 1ns/10ps
interface wdrc_tick_if;
   logic tick; // One-cycle pulse per low-frequency period
   modport src (output tick);
   modport dst (input tick);
endinterface

// [logic/wdrc_tick_gen.sv]
// Divider making the low-frequency tick from the system clock
`timescale 1ns/10ps
module wdrc_tick_gen
   import wdrc_pkg::*;
#(
   parameter int DIV = WDRC_LF_DIV // Clock cycles per tick
) (
   input  wire logic   clock,
   input  wire logic   nrst,
   wdrc_tick_if.src    tk
);
   logic [15:0] cnt_ff; // Divider count
   wire         wrap = (cnt_ff == 16'(DIV - 1));
   // ==========================================================
   // Divider; rounding down makes the tick slightly fast, never slow
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_ff  <= 16'h0000;
         tk.tick <= 1'b0;
      end else begin
         cnt_ff  <= wrap ? 16'h0000 : cnt_ff + 16'h0001;
         tk.tick <= wrap;
      end
   end
endmodule

// [bench/tb.sv]
// Self-checking bench for the watchdog reload block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
   $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb
   import wdrc_pkg::*;
;
   // ==========================================================
   // Stimulus and observed signals
   logic        clock = 1'b0;  // 100 MHz system clock
   logic        nrst = 1'b0;   // Async reset, active low
   logic [11:0] addr = 12'h000; // Register address
   logic [31:0] wdata = 32'h00000000; // Write data
   logic        wr_en = 1'b0;  // Write strobe
   logic        rd_en = 1'b0;  // Read strobe
   logic        cpu_sleep = 1'b0; // CPU sleep level
   logic        cpu_halt = 1'b0;  // Debug halt level
   logic [31:0] rdata;         // Read data, cycle after read
   logic        irq;           // Level interrupt
   logic        wdog_reset;    // Sticky watchdog reset
   logic        run_indicator; // High once started
   logic [31:0] rv;            // Last read value
   int          n_errors = 0;  // Mismatch count
   int          samples_checked = 0; // Comparison count
   localparam int TK = WDRC_LF_DIV; // Clocks per low-frequency tick

   always #5 clock = ~clock;

   wdrc_top i_wdrc_top (
      .clock         (clock),
      .nrst          (nrst),
      .addr          (addr),
      .wdata         (wdata),
      .wr_en         (wr_en),
      .rd_en         (rd_en),
      .cpu_sleep     (cpu_sleep),
      .cpu_halt      (cpu_halt),
      .rdata         (rdata),
      .irq           (irq),
      .wdog_reset    (wdog_reset),
      .run_indicator (run_indicator)
   );

   // ==========================================================
   // Bus tasks: one-cycle strobes, read data sampled in the next cycle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      rv = rdata;
   endtask

   // ==========================================================
   // Closing task, the one place the run ends
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenario: values after reset, unmapped place reads zero
   task automatic t_reset_values;
      rd(WDRC_OFF_RELOAD);  `CHK("reload", 32'hFFFFFFFF, rv)
      rd(WDRC_OFF_ENMASK);  `CHK("enmask", 32'h00000001, rv)
      rd(WDRC_OFF_PAUSE);   `CHK("pause", 32'h00000001, rv)
      rd(WDRC_OFF_RUN);     `CHK("run", 32'h00000000, rv)
      rd(12'h7F0);          `CHK("unmapped", 32'h00000000, rv)
   endtask

   // Scenario: configure, clamp, start, then writes are blocked
   task automatic t_config_lock;
      wr(WDRC_OFF_RELOAD, 32'h00000003);
      rd(WDRC_OFF_RELOAD);  `CHK("clamp", 32'h0000000F, rv)
      wr(WDRC_OFF_ENMASK, 32'h00000005);
      rd(WDRC_OFF_ENMASK);  `CHK("enmask", 32'h00000005, rv)
      // Sleep pauses, halt keeps running
      wr(WDRC_OFF_PAUSE, 32'h00000008);
      rd(WDRC_OFF_PAUSE);   `CHK("pause", 32'h00000008, rv)
      wr(WDRC_OFF_START, 32'h00000001);
      @(posedge clock); #1;
      `CHK("running", 1'b1, run_indicator)
      wr(WDRC_OFF_RELOAD, 32'h00000020);
      wr(WDRC_OFF_ENMASK, 32'h000000FF);
      wr(WDRC_OFF_PAUSE, 32'h00000001);
      rd(WDRC_OFF_RELOAD);  `CHK("lock reload", 32'h0000000F, rv)
      rd(WDRC_OFF_ENMASK);  `CHK("lock enmask", 32'h00000005, rv)
      rd(WDRC_OFF_PAUSE);   `CHK("lock pause", 32'h00000008, rv)
   endtask

   // Scenario: wrong value ignored, reload only after all enabled requests
   task automatic t_requests;
      rd(WDRC_OFF_REQ);     `CHK("req idle", 32'h00000005, rv)
      wr(WDRC_OFF_RRBASE, 32'h6E524634);
      rd(WDRC_OFF_REQ);     `CHK("req bad", 32'h00000005, rv)
      wr(WDRC_OFF_RRBASE + 12'h004, WDRC_MAGIC);
      rd(WDRC_OFF_REQ);     `CHK("req dis", 32'h00000005, rv)
      wr(WDRC_OFF_RRBASE, WDRC_MAGIC);
      rd(WDRC_OFF_REQ);     `CHK("req one", 32'h00000004, rv)
      wr(WDRC_OFF_RRBASE + 12'h008, WDRC_MAGIC);
      rd(WDRC_OFF_REQ);     `CHK("req done", 32'h00000005, rv)
   endtask

   // Scenario: timed timeout with a paused stretch, then delayed reset
   task automatic t_timeout;
      int c;
      c = 0;
      wr(WDRC_OFF_INTMASK, 32'h00000001);
      @(posedge clock);
      cpu_sleep <= 1'b1;
      repeat (4) @(posedge clock);
      // Reload restarts the count with sleep already seen
      wr(WDRC_OFF_RRBASE, WDRC_MAGIC);
      wr(WDRC_OFF_RRBASE + 12'h008, WDRC_MAGIC);
      while (irq !== 1'b1 && c < 21 * TK) begin
         @(posedge clock);
         c++;
         if (c == 4 * TK) begin
            cpu_sleep <= 1'b0;
            cpu_halt <= 1'b1;
         end
      end
      #1;
      `CHK("irq", 1'b1, irq)
      `CHK("not early", 1'b1, c >= 19 * TK - 10)
      `CHK("not late", 1'b1, c <= 20 * TK + 10)
      `CHK("reset held", 1'b0, wdog_reset)
      rd(WDRC_OFF_INTSTAT); `CHK("status", 32'h00000001, rv)
      @(posedge clock); #1;
      `CHK("irq clear", 1'b0, irq)
      repeat (TK - 20) @(posedge clock);
      #1;
      `CHK("still held", 1'b0, wdog_reset)
      c = 0;
      while (wdog_reset !== 1'b1 && c < TK + 40) begin
         @(posedge clock);
         c++;
      end
      #1;
      `CHK("reset", 1'b1, wdog_reset)
      repeat (3) @(posedge clock);
      #1;
      `CHK("reset sticky", 1'b1, wdog_reset)
   endtask

   // ==========================================================
   // Main sequence and watchdog against a hang
   initial begin
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      t_reset_values;
      t_config_lock;
      t_requests;
      t_timeout;
      test_done;
   end

   initial begin
      repeat (90000) @(posedge clock);
      n_errors++;
      test_done;
   end
endmodule
